// ---- scm_clock_mgmt.sv ----
// Implementation choices: the address-and-strobe port and the register offsets.
`include "scm_cfg.svh"
// Operation
// RULE_01 - separate tx and rx sections, 16x32 transfers
// RULE_02 - start automatically or on frame-sync event
// RULE_03 - each section may follow other's clock/start
// RULE_04 - external clock at most half system clock
// RULE_05 - tx clock from pin, rx, or divider
// RULE_06 - rx clock from pin, tx, or divider
// RULE_07 - each section may drive its clock pin
// RULE_08 - 12-bit half-period count, ratio up to 8190
// RULE_09 - one divided clock feeds both selectors
// RULE_10 - zero count keeps divider inactive
// RULE_11 - divided clock high N, low N
// RULE_12 - tx source field and internal inversion
// RULE_13 - tx pin continuous or during transfer
// RULE_14 - tx inversion leaves pin clock unchanged
// RULE_15 - software avoids tx pin with continuous output
// RULE_16 - rx source field and internal inversion
// RULE_17 - rx pin continuous or during transfer
// RULE_18 - rx inversion leaves pin clock unchanged
// RULE_19 - software avoids rx pin with continuous output
// RULE_20 - unmasked pending source asserts interrupt line
// RULE_21 - two dma channels, tx and rx words
// RULE_22 - software enables peripheral clock first
// RULE_23 - start detection and frame-sync per start field
// RULE_24 - divider restarts low on count rewrite
// RULE_25 - pin clocks and syncs synchronised first
module scm_clock_mgmt
    import scm_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // transmit pins
    input wire logic transmit_clock_pin_i,
    output logic transmit_clock_pin_o,
    output logic transmit_clock_pin_oe,
    input wire logic transmit_frame_sync_i,
    output logic transmit_frame_sync_o,
    output logic transmit_frame_sync_oe,
    // receive pins
    input wire logic receive_clock_pin_i,
    output logic receive_clock_pin_o,
    output logic receive_clock_pin_oe,
    input wire logic receive_frame_sync_i,
    output logic receive_frame_sync_o,
    output logic receive_frame_sync_oe,
    // dma word streams
    input wire logic tx_dma_valid,
    input wire logic [31:0] tx_dma_data,
    output logic tx_dma_ready,
    output logic rx_dma_valid,
    output logic [31:0] rx_dma_data,
    // internal bit clocks, activity flags and interrupt (system-clock-rate levels)
    output logic tx_bit_clk,
    output logic rx_bit_clk,
    output logic tx_active,
    output logic rx_active,
    output logic irq
);

// ----------------------------------------
// registers
// ----------------------------------------
logic [`SCM_DIV_W-1:0] div_count;
scm_cmr_t tcmr;
scm_cmr_t rcmr;
logic tx_en;
logic rx_en;
logic [1:0] imr;
logic div_load;

// mode word to fields; start field sits above a gap
function automatic scm_cmr_t cmr_unpack(logic [31:0] w);
    scm_cmr_t c;
    c.start = scm_start_t'(w[`SCM_START_LSB +: 4]);
    c.clock_invert = w[`SCM_CKI_BIT];
    c.clock_output_mode = scm_cko_t'(w[`SCM_CKO_LSB +: 3]);
    c.clock_source_select = scm_cks_t'(w[`SCM_CKS_LSB +: 2]);
    return c;
endfunction

// register writes
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        div_count <= `SCM_DIV_RST;
        tcmr <= scm_cmr_t'(10'(`SCM_CMR_RST));
        rcmr <= scm_cmr_t'(10'(`SCM_CMR_RST));
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        imr <= 2'b00;
    end else if (reg_wr) begin
        case (reg_addr)
            `SCM_OFS_DIV: div_count <= reg_wdata[`SCM_DIV_W-1:0];
            `SCM_OFS_TCMR: tcmr <= cmr_unpack(reg_wdata);
            `SCM_OFS_RCMR: rcmr <= cmr_unpack(reg_wdata);
            `SCM_OFS_CTRL: begin
                tx_en <= reg_wdata[`SCM_CTRL_TEN];
                rx_en <= reg_wdata[`SCM_CTRL_REN];
            end
            `SCM_OFS_IMR: imr <= reg_wdata[1:0];
            default: ;
        endcase
    end
end
assign div_load = reg_wr && (reg_addr == `SCM_OFS_DIV);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
logic [3:0] sync_a;
logic [3:0] sync_b;
// RULE_25 two flops
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        sync_a <= 4'h0;
        sync_b <= 4'h0;
    end else begin
        sync_a <= {receive_frame_sync_i, transmit_frame_sync_i, receive_clock_pin_i, transmit_clock_pin_i};
        sync_b <= sync_a;
    end
end

// ----------------------------------------
// clock divider
// ----------------------------------------
logic [`SCM_DIV_W-1:0] div_cnt;
logic div_clk;
// RULE_08 RULE_10 RULE_11 RULE_24 divider
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        div_cnt <= `SCM_DIV_RST;
        div_clk <= 1'b0;
    end else if (div_load || div_count == `SCM_DIV_RST) begin
        div_cnt <= `SCM_DIV_RST;
        div_clk <= 1'b0;
    end else if (div_cnt == div_count - 12'h001) begin
        div_cnt <= `SCM_DIV_RST;
        div_clk <= ~div_clk;
    end else begin
        div_cnt <= div_cnt + 12'h001;
    end
end

// ----------------------------------------
// clock selection
// ----------------------------------------
logic tx_sel_clk;
logic rx_sel_clk;
logic tx_ext;
logic rx_ext;
// RULE_25 synchronised pin clocks
assign tx_ext = sync_b[0];
assign rx_ext = sync_b[1];
// RULE_03 RULE_05 RULE_09 RULE_12 tx source
always_comb begin
    case (tcmr.clock_source_select)
        SCM_CKS_DIV: tx_sel_clk = div_clk;
        SCM_CKS_OTHER: tx_sel_clk = rx_sel_raw();
        SCM_CKS_PIN: tx_sel_clk = tx_ext;
        default: tx_sel_clk = 1'b0;
    endcase
end
// RULE_03 RULE_06 RULE_09 RULE_16 rx source; no loop back
always_comb begin
    case (rcmr.clock_source_select)
        SCM_CKS_DIV: rx_sel_clk = div_clk;
        SCM_CKS_OTHER: rx_sel_clk = tx_sel_raw();
        SCM_CKS_PIN: rx_sel_clk = rx_ext;
        default: rx_sel_clk = 1'b0;
    endcase
end
// one-level view of the other section, no combinational loop
function automatic logic rx_sel_raw();
    return (rcmr.clock_source_select == SCM_CKS_PIN) ? rx_ext : div_clk;
endfunction
function automatic logic tx_sel_raw();
    return (tcmr.clock_source_select == SCM_CKS_PIN) ? tx_ext : div_clk;
endfunction

// RULE_12 RULE_16 inversion on internal clock only
assign tx_bit_clk = tx_sel_clk ^ tcmr.clock_invert;
assign rx_bit_clk = rx_sel_clk ^ rcmr.clock_invert;

// ----------------------------------------
// start detection and transfer window
// ----------------------------------------
logic [1:0] fs_prev;
logic [1:0] bclk_prev;
logic tx_start;
logic rx_start;
scm_state_t tx_state;
scm_state_t rx_state;
logic [9:0] tx_bits;
logic [9:0] rx_bits;

// start event per selected mode
function automatic logic start_hit(scm_start_t s, logic fs, logic fp, logic other, logic en);
    case (s)
        SCM_ST_CONT: return en;
        SCM_ST_OTHER: return other;
        SCM_ST_LOW: return !fs;
        SCM_ST_HIGH: return fs;
        SCM_ST_FALL: return fp && !fs;
        SCM_ST_RISE: return !fp && fs;
        SCM_ST_LVL, SCM_ST_ANY: return fp != fs;
        default: return 1'b0;
    endcase
endfunction

always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        fs_prev <= 2'b00;
        bclk_prev <= 2'b00;
    end else begin
        fs_prev <= sync_b[3:2];
        bclk_prev <= {rx_bit_clk, tx_bit_clk};
    end
end

// RULE_02 RULE_03 RULE_23 start events
assign tx_start = tx_en && start_hit(tcmr.start, sync_b[2], fs_prev[0], rx_state == SCM_RUN, tx_dma_valid);
assign rx_start = rx_en && start_hit(rcmr.start, sync_b[3], fs_prev[1], tx_state == SCM_RUN, 1'b1);

// RULE_01 transfer length 16 words of 32 bits
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        tx_state <= SCM_IDLE;
        tx_bits <= 10'h000;
    end else begin
        case (tx_state)
            SCM_IDLE: if (tx_start) begin
                tx_state <= SCM_RUN;
                tx_bits <= 10'h000;
            end
            SCM_RUN: if (!tx_en) tx_state <= SCM_IDLE;
            else if (tx_bit_clk && !bclk_prev[0]) begin
                if (tx_bits == 10'(`SCM_MAX_WORDS * `SCM_MAX_BITS - 1)) tx_state <= SCM_DONE;
                tx_bits <= tx_bits + 10'h001;
            end
            SCM_DONE: tx_state <= SCM_IDLE;
            default: tx_state <= SCM_IDLE;
        endcase
    end
end

always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        rx_state <= SCM_IDLE;
        rx_bits <= 10'h000;
    end else begin
        case (rx_state)
            SCM_IDLE: if (rx_start) begin
                rx_state <= SCM_RUN;
                rx_bits <= 10'h000;
            end
            SCM_RUN: if (!rx_en) rx_state <= SCM_IDLE;
            else if (rx_bit_clk && !bclk_prev[1]) begin
                if (rx_bits == 10'(`SCM_MAX_WORDS * `SCM_MAX_BITS - 1)) rx_state <= SCM_DONE;
                rx_bits <= rx_bits + 10'h001;
            end
            SCM_DONE: rx_state <= SCM_IDLE;
            default: rx_state <= SCM_IDLE;
        endcase
    end
end
assign tx_active = (tx_state == SCM_RUN);
assign rx_active = (rx_state == SCM_RUN);

// RULE_23 frame sync driven as pulse at start
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        transmit_frame_sync_o <= 1'b0;
        receive_frame_sync_o <= 1'b0;
    end else begin
        transmit_frame_sync_o <= (tx_state == SCM_IDLE) && tx_start;
        receive_frame_sync_o <= (rx_state == SCM_IDLE) && rx_start;
    end
end
// output only when start is not taken from the pin
assign transmit_frame_sync_oe = (tcmr.start == SCM_ST_CONT) || (tcmr.start == SCM_ST_OTHER);
assign receive_frame_sync_oe = (rcmr.start == SCM_ST_CONT) || (rcmr.start == SCM_ST_OTHER);

// ----------------------------------------
// clock pin outputs
// ----------------------------------------
// RULE_07 RULE_14 RULE_18 uninverted clock to pin
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        transmit_clock_pin_o <= 1'b0;
        receive_clock_pin_o <= 1'b0;
    end else begin
        transmit_clock_pin_o <= tx_sel_clk;
        receive_clock_pin_o <= rx_sel_clk;
    end
end
// RULE_07 RULE_13 RULE_17 pin enables
assign transmit_clock_pin_oe = (tcmr.clock_output_mode == SCM_CKO_CONT) || (tcmr.clock_output_mode == SCM_CKO_XFER && tx_active);
assign receive_clock_pin_oe = (rcmr.clock_output_mode == SCM_CKO_CONT) || (rcmr.clock_output_mode == SCM_CKO_XFER && rx_active);

// ----------------------------------------
// dma words
// ----------------------------------------
// RULE_21 one word per 32 tx bits, rx word per 32 bits
assign tx_dma_ready = tx_active && tx_bit_clk && !bclk_prev[0] && (tx_bits[4:0] == 5'h1f);
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        rx_dma_valid <= 1'b0;
        rx_dma_data <= 32'h0000_0000;
    end else begin
        rx_dma_valid <= rx_active && rx_bit_clk && !bclk_prev[1] && (rx_bits[4:0] == 5'h1f);
        rx_dma_data <= {22'h00_0000, rx_bits};
    end
end

// ----------------------------------------
// status and interrupt
// ----------------------------------------
logic [1:0] stat;
// sticky end-of-transfer flags, set beats read-clear
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        stat <= 2'b00;
    end else begin
        stat <= ((reg_rd && reg_addr == `SCM_OFS_STAT) ? 2'b00 : stat)
            | {rx_state == SCM_DONE, tx_state == SCM_DONE};
    end
end
// RULE_20 unmasked pending sources
assign irq = |(stat & imr);

// read data one cycle later
always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        case (reg_addr)
            `SCM_OFS_DIV: reg_rdata <= {20'h0_0000, div_count};
            `SCM_OFS_TCMR: reg_rdata <= {20'h0_0000, tcmr.start, 2'b00, tcmr.clock_invert, tcmr.clock_output_mode, tcmr.clock_source_select};
            `SCM_OFS_RCMR: reg_rdata <= {20'h0_0000, rcmr.start, 2'b00, rcmr.clock_invert, rcmr.clock_output_mode, rcmr.clock_source_select};
            `SCM_OFS_CTRL: reg_rdata <= {23'h00_0000, tx_en, 7'h00, rx_en};
            `SCM_OFS_STAT: reg_rdata <= {28'h000_0000, rx_active, tx_active, stat};
            `SCM_OFS_IMR: reg_rdata <= {30'h0000_0000, imr};
            default: reg_rdata <= 32'h0000_0000;
        endcase
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

// ----------------------------------------
// assertions
// ----------------------------------------
default clocking @(posedge clk_sys); endclocking
default disable iff (!resetn);

sequence s_div_high;
    $rose(div_clk);
endsequence
a_div_zero_idle: assert property (div_count == 12'h000 |=> !div_clk) // RULE_10
    else $error("divider active with zero count");
a_div_high_len: assert property (s_div_high and div_count == 12'h003 && !div_load |=> div_clk) // RULE_11
    else $error("divided high phase too short");
a_div_restart: assert property (div_load |=> !div_clk && div_cnt == 12'h000) // RULE_24
    else $error("divider not restarted on rewrite");
a_tx_pin_raw: assert property (transmit_clock_pin_o == $past(tx_sel_clk)) // RULE_14
    else $error("tx pin clock altered");
a_rx_pin_raw: assert property (receive_clock_pin_o == $past(rx_sel_clk)) // RULE_18
    else $error("rx pin clock altered");
a_tx_oe_xfer: assert property (tcmr.clock_output_mode == SCM_CKO_XFER && !tx_active |-> !transmit_clock_pin_oe) // RULE_13
    else $error("tx pin driven outside transfer");
a_rx_oe_cont: assert property (rcmr.clock_output_mode == SCM_CKO_CONT |-> receive_clock_pin_oe) // RULE_17
    else $error("rx pin not driven continuously");
a_tx_div_src: assert property (tcmr.clock_source_select == SCM_CKS_DIV |-> tx_bit_clk == (div_clk ^ tcmr.clock_invert)) // RULE_05
    else $error("tx clock not from divider");
a_rx_start: assert property (rx_state == SCM_IDLE && rx_start |=> rx_state == SCM_RUN ##0 receive_frame_sync_o) // RULE_23
    else $error("rx start not taken");
a_irq_mask: assert property (tx_state == SCM_DONE && imr[0] && !reg_wr |=> irq) // RULE_20
    else $error("unmasked done flag gave no interrupt");

endmodule

// ---- scm_cfg.svh ----
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SCM_OFS_DIV 8'h04
`define SCM_OFS_TCMR 8'h18
`define SCM_OFS_RCMR 8'h10
`define SCM_OFS_CTRL 8'h00
`define SCM_OFS_STAT 8'h40
`define SCM_OFS_IMR 8'h4c

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCM_DIV_W 12
`define SCM_CKS_LSB 0
`define SCM_CKO_LSB 2
`define SCM_CKI_BIT 5
`define SCM_START_LSB 8
`define SCM_CTRL_REN 0
`define SCM_CTRL_TEN 8

// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define SCM_MAX_WORDS 16
`define SCM_MAX_BITS 32
`define SCM_DIV_RST 12'h000
`define SCM_CMR_RST 32'h0000_0000
`define SCM_WORD_BITS 6'h20

`endif

// ---- scm_pkg.sv ----
package scm_pkg;
    // clock source selection
    typedef enum logic [1:0] {
        SCM_CKS_DIV = 2'b00,
        SCM_CKS_OTHER = 2'b01,
        SCM_CKS_PIN = 2'b10
    } scm_cks_t;

    // clock pin output mode
    typedef enum logic [2:0] {
        SCM_CKO_NONE = 3'b000,
        SCM_CKO_CONT = 3'b001,
        SCM_CKO_XFER = 3'b010
    } scm_cko_t;

    // start event selection
    typedef enum logic [3:0] {
        SCM_ST_CONT = 4'h0,
        SCM_ST_OTHER = 4'h1,
        SCM_ST_LOW = 4'h2,
        SCM_ST_HIGH = 4'h3,
        SCM_ST_FALL = 4'h4,
        SCM_ST_RISE = 4'h5,
        SCM_ST_LVL = 4'h6,
        SCM_ST_ANY = 4'h7
    } scm_start_t;

    // section state, gray along idle-run-done
    typedef enum logic [1:0] {
        SCM_IDLE = 2'b00,
        SCM_RUN = 2'b01,
        SCM_DONE = 2'b11
    } scm_state_t;

    // clock mode register contents
    typedef struct packed {
        scm_start_t start;
        logic clock_invert;
        scm_cko_t clock_output_mode;
        scm_cks_t clock_source_select;
    } scm_cmr_t;

    // pin pair (output and enable) for a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } scm_pin_t;
endpackage

// ---- scm_codec_model.sv ----
// far-side serial peer: makes pin clocks and frame levels
module scm_codec_model (
    // system
    input wire logic clk_sys,
    // levels the peer puts on the shared pins
    output logic txc_drv,
    output logic rxc_drv,
    output logic txf_drv,
    output logic rxf_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins rest low, clock stands still outside bursts
    initial begin
        txc_drv = 1'b0;
        rxc_drv = 1'b0;
        txf_drv = 1'b0;
        rxf_drv = 1'b0;
    end

    task automatic burst(input bit rx, input int half, input int toggles);
        int h;
        h = (half < 2) ? 2 : half;
        repeat (toggles) begin
            repeat (h) @(posedge clk_sys);
            if (rx) rxc_drv <= ~rxc_drv;
            else txc_drv <= ~txc_drv;
        end
    endtask

    // frame line level change, launched after an edge
    task automatic frame(input bit rx, input bit lvl);
        @(posedge clk_sys);
        if (rx) rxf_drv <= lvl;
        else txf_drv <= lvl;
    endtask
endmodule

// ---- tb.sv ----
`include "scm_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, tx_dma_valid = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rdv;
    logic txc_o, txc_oe, txf_o, txf_oe, rxc_o, rxc_oe, rxf_o, rxf_oe;
    logic txc_drv, rxc_drv, txf_drv, rxf_drv, txc_pin, rxc_pin, txf_pin, rxf_pin;
    logic tx_bit_clk, rx_bit_clk, tx_active, rx_active, irq, tx_rdy, rx_dv;
    int fail_count = 0, checks_done = 0, hi, lo, n, rdy;

    always #2 clk_sys = ~clk_sys;

    // pin level: whichever party has its enable up
    assign txc_pin = txc_oe ? txc_o : txc_drv;
    assign rxc_pin = rxc_oe ? rxc_o : rxc_drv;
    assign txf_pin = txf_oe ? txf_o : txf_drv;
    assign rxf_pin = rxf_oe ? rxf_o : rxf_drv;

    scm_clock_mgmt scm_clock_mgmt_inst (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transmit_clock_pin_i(txc_pin), .transmit_clock_pin_o(txc_o), .transmit_clock_pin_oe(txc_oe),
        .transmit_frame_sync_i(txf_pin), .transmit_frame_sync_o(txf_o), .transmit_frame_sync_oe(txf_oe),
        .receive_clock_pin_i(rxc_pin), .receive_clock_pin_o(rxc_o), .receive_clock_pin_oe(rxc_oe),
        .receive_frame_sync_i(rxf_pin), .receive_frame_sync_o(rxf_o), .receive_frame_sync_oe(rxf_oe),
        .tx_dma_valid(tx_dma_valid), .tx_dma_data(32'h0000_0000), .tx_dma_ready(tx_rdy),
        .rx_dma_valid(rx_dv), .rx_dma_data(), .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk),
        .tx_active(tx_active), .rx_active(rx_active), .irq(irq)
    );

    scm_codec_model scm_codec_model_inst (
        .clk_sys(clk_sys), .txc_drv(txc_drv), .rxc_drv(rxc_drv), .txf_drv(txf_drv), .rxf_drv(rxf_drv)
    );

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // strobe dropped a full edge later, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? tx_bit_clk : (w == 1) ? rx_bit_clk : txc_o;
    endfunction

    // widths of one high and the following low phase
    task automatic phases(input int w);
        n = 0;
        while (pick(w) !== 1'b0 && n < 9000) begin step(); n++; end
        while (pick(w) !== 1'b1 && n < 9000) begin step(); n++; end
        hi = 0;
        while (pick(w) === 1'b1 && hi < 9000) begin step(); hi++; end
        lo = 0;
        while (pick(w) === 1'b0 && lo < 9000) begin step(); lo++; end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] ofs [5] = '{`SCM_OFS_CTRL, `SCM_OFS_DIV, `SCM_OFS_RCMR, `SCM_OFS_TCMR, `SCM_OFS_IMR};
        foreach (ofs[i]) begin rd(ofs[i]); chk("reset value", 32'h0000_0000, rdv); end
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20);
        chk("unmapped read", 32'h0000_0000, rdv);
        wr(`SCM_OFS_DIV, 32'hFFFF_FFFF);
        rd(`SCM_OFS_DIV);
        chk("count width", 32'h0000_0FFF, rdv);
    endtask

    task automatic t_div();
        int nv [4] = '{1, 3, 7, 4095};
        wr(`SCM_OFS_TCMR, 32'h0000_0000);
        wr(`SCM_OFS_RCMR, 32'h0000_0000);
        foreach (nv[i]) begin
            wr(`SCM_OFS_DIV, nv[i]);
            phases(0);
            chk("tx high", nv[i], hi);
            chk("tx low", nv[i], lo);
            phases(1);
            chk("rx high", nv[i], hi);
        end
        wr(`SCM_OFS_DIV, 32'h0000_0000);
        repeat (10) step();
        n = 0;
        repeat (60) begin lo = tx_bit_clk; step(); n += (tx_bit_clk !== lo); end
        chk("idle divider", 0, n);
    endtask

    // inversion moves the internal clock only, compared by agreement count
    task automatic t_inv();
        wr(`SCM_OFS_DIV, 32'h0000_0004);
        for (int k = 0; k < 2; k++) begin
            wr(`SCM_OFS_TCMR, 32'h0000_0004 | (k << 5));
            wr(`SCM_OFS_RCMR, 32'h0000_0004 | (k << 5));
            n = 0;
            repeat (64) begin step(); n += (tx_bit_clk === txc_o) + (rx_bit_clk === rxc_o); end
            chk("inversion agreement", k ? 0 : 1, n > 64);
            chk("continuous enable", 2, txc_oe + rxc_oe);
        end
    endtask

    // pin source only with output off
    task automatic t_pin();
        for (int s = 0; s < 2; s++) begin
            wr(s ? `SCM_OFS_RCMR : `SCM_OFS_TCMR, 32'h0000_0002);
            wr(s ? `SCM_OFS_TCMR : `SCM_OFS_RCMR, 32'h0000_0001);
            chk("pin released", 0, s ? rxc_oe : txc_oe);
            fork
                scm_codec_model_inst.burst(s, 5, 12);
                begin
                    phases(s);
                    chk("pin clock high", 5, hi);
                    phases(1 - s);
                    chk("other clock low", 5, lo);
                end
            join
        end
    endtask

    task automatic t_xfer();
        wr(`SCM_OFS_DIV, 32'h0000_0001);
        wr(`SCM_OFS_TCMR, 32'h0000_0008);
        wr(`SCM_OFS_IMR, 32'h0000_0001);
        chk("output idle", 0, txc_oe);
        tx_dma_valid <= 1'b1;
        wr(`SCM_OFS_CTRL, 32'h0000_0100);
        n = 0;
        while (tx_active !== 1'b1 && n < 50) begin step(); n++; end
        chk("output in transfer", 1, txc_oe);
        hi = 0;
        n = 0;
        rdy = 0;
        while (tx_active === 1'b1 && n < 3000) begin
            lo = tx_bit_clk;
            step();
            n++;
            hi += (!lo && tx_bit_clk);
            rdy += tx_rdy;
        end
        chk("bits per transfer", 1, hi >= 511 && hi <= 513);
        chk("dma words", `SCM_MAX_WORDS, rdy);
        tx_dma_valid <= 1'b0;
        wr(`SCM_OFS_CTRL, 32'h0000_0000);
        chk("output after", 0, txc_oe);
        chk("irq raised", 1, irq);
        rd(`SCM_OFS_STAT);
        chk("done flag", 1, rdv[0]);
        step();
        chk("irq cleared", 0, irq);
        wr(`SCM_OFS_IMR, 32'h0000_0000);
    endtask

    task automatic t_start();
        int md [5] = '{2, 3, 4, 5, 6};
        bit idl [5] = '{1, 0, 1, 0, 0};
        foreach (md[i]) begin
            scm_codec_model_inst.frame(1, idl[i]);
            wr(`SCM_OFS_RCMR, md[i] << 8);
            wr(`SCM_OFS_CTRL, 32'h0000_0001);
            repeat (20) step();
            chk("no early start", 0, rx_active);
            chk("sync input", 0, rxf_oe);
            scm_codec_model_inst.frame(1, !idl[i]);
            n = 0;
            while (rx_active !== 1'b1 && n < 20) begin step(); n++; end
            chk("event start", 1, rx_active);
            wr(`SCM_OFS_CTRL, 32'h0000_0000);
            repeat (4) step();
        end
        wr(`SCM_OFS_RCMR, 32'h0000_0100);
        wr(`SCM_OFS_TCMR, 32'h0000_0000);
        tx_dma_valid <= 1'b1;
        wr(`SCM_OFS_CTRL, 32'h0000_0101);
        n = 0;
        while (rx_active !== 1'b1 && n < 50) begin step(); n++; end
        chk("start with tx", 1, rx_active);
        n = 0;
        while (rx_dv !== 1'b1 && n < 100) begin step(); n++; end
        chk("rx word", 1, rx_dv);
        tx_dma_valid <= 1'b0;
        wr(`SCM_OFS_CTRL, 32'h0000_0000);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs();
        t_div();
        t_inv();
        t_pin();
        t_xfer();
        t_start();
        complete_run();
    end

    // watchdog well beyond the expected span
    initial begin
        repeat (80000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end
endmodule
